// ### verilog/dcp_conn_ctrl.sv
`timescale 1ns/1ps
`include "dcp_regs.svh"

// Overview of operation
// - Preemption replaces an existing dedicated connection with a new one.
// - Preemption request uses SOFc1 with Word 4 bit 31 set.
// - Accept F_RJT with preemption reason, or matching ACK_1/ACK_N on SOFn1.
// - Acknowledgement to a preemption request means connection established.
// - F_RJT with a preemption reason ends a preemption attempt, no connection.
// - Priority rides in Word 4 bits 30-24; fabric may reject by it.
// - After preemption, ordinary connect and disconnect handling applies.
// - Source connects on ACK with SOFn1, swapped ids, EOFn or EOFt.
// - Free unconnected destination answers ACK on SOFn1, becomes recipient.
// - Connected recipient may start sequences toward initiator with SOFi1.
// - Busy unconnected destination answers P_BSY ending in EOFdt.
// - Preemption is used only for Class 1 and Class 6.
// - Preemption only when attached through a fabric.
// - Word 4 bits 31-16 hold priority and originator id, or id alone.
// - After a preemption request, hold frames until the response arrives.
module dcp_conn_ctrl (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [23:0] myId,
    input wire logic fabricAttached,
    input wire logic prioEnabled,
    input wire logic portBusy,
    input wire logic disconnect,
    input wire logic reqValid,
    input wire dcp_pkg::dcp_req_t req,
    input wire logic seqValid,
    input wire logic rxValid,
    input wire dcp_pkg::dcp_frame_t rxFrame,
    output logic reqAccept_r,
    output logic txValid_r,
    output dcp_pkg::dcp_frame_t txFrame_r,
    output logic connected_r,
    output logic isInitiator_r,
    output logic reqDone_r,
    output logic reqFailed_r,
    output logic reqInvalid_r,
    output logic seqAccept_r
);
    dcp_pkg::dcp_state_t state_r, state_nxt;
    dcp_pkg::dcp_frame_t txFrame_nxt;
    logic txValid_nxt, connected_nxt, isInitiator_nxt;
    logic reqAccept_nxt, reqDone_nxt, reqFailed_nxt, reqInvalid_nxt;
    logic seqAccept_nxt, pendPreempt_r, pendPreempt_nxt;
    logic [23:0] peer_r, peer_nxt;
    logic [31:0] word4;
    logic classOk, respMatch, isAck, isRjtPreempt, connReqIn;

    // Priority shares the originator id field only when enabled
    always_comb begin
        word4 = 32'h0000_0000;
        if (prioEnabled) begin
            word4[`DCP_W4_PRIO_HI:`DCP_W4_PRIO_LO] = req.prio;
            word4[`DCP_W4_OXID_HI:`DCP_W4_OXID_LO] = req.oxId[7:0];
        end else begin
            word4[`DCP_W4_PREEMPT_BIT:`DCP_W4_OXID_LO] = req.oxId;
        end
        // Preemption flag overlays the top of the field
        if (req.preempt) begin
            word4[`DCP_W4_PREEMPT_BIT] = 1'b1;
        end
    end

    assign classOk = (req.svcClass == `DCP_CLASS_1) ||
        (req.svcClass == `DCP_CLASS_6);
    // Answer must carry SOFn1 and ids swapped against the request
    assign respMatch = rxValid && rxFrame.sof == `DCP_SOF_N1 &&
        rxFrame.sid == peer_r && rxFrame.did == myId;
    // Preemption requests accept ACK_1/ACK_N only; plain adds ACK_0
    assign isAck = (rxFrame.kind == `DCP_FK_ACK1 ||
        rxFrame.kind == `DCP_FK_ACKN ||
        (!pendPreempt_r && rxFrame.kind == `DCP_FK_ACK0)) &&
        (rxFrame.eof == `DCP_EOF_N || rxFrame.eof == `DCP_EOF_T);
    assign isRjtPreempt = rxFrame.kind == `DCP_FK_FRJT &&
        (rxFrame.reason == `DCP_RSN_PREEMPT_REJ ||
        rxFrame.reason == `DCP_RSN_PREEMPT_NEN);
    assign connReqIn = rxValid && rxFrame.sof == `DCP_SOF_C1 &&
        rxFrame.did == myId;

    always_comb begin
        state_nxt = state_r;
        txValid_nxt = 1'b0;
        txFrame_nxt = txFrame_r;
        connected_nxt = connected_r;
        isInitiator_nxt = isInitiator_r;
        reqAccept_nxt = 1'b0;
        reqDone_nxt = 1'b0;
        reqFailed_nxt = 1'b0;
        reqInvalid_nxt = 1'b0;
        seqAccept_nxt = 1'b0;
        pendPreempt_nxt = pendPreempt_r;
        peer_nxt = peer_r;
        unique case (state_r)
            dcp_pkg::DCP_IDLE: begin
                if (connReqIn) begin
                    txValid_nxt = 1'b1;
                    txFrame_nxt.sof = `DCP_SOF_N1;
                    txFrame_nxt.sid = myId;
                    txFrame_nxt.did = rxFrame.sid;
                    txFrame_nxt.word4 = rxFrame.word4;
                    txFrame_nxt.reason = 8'h00;
                    if (portBusy) begin
                        txFrame_nxt.kind = `DCP_FK_PBSY;
                        txFrame_nxt.eof = `DCP_EOF_DT;
                    end else begin
                        txFrame_nxt.kind = `DCP_FK_ACK1;
                        txFrame_nxt.eof = `DCP_EOF_N;
                        connected_nxt = 1'b1;
                        isInitiator_nxt = 1'b0;
                        peer_nxt = rxFrame.sid;
                        state_nxt = dcp_pkg::DCP_CONN;
                    end
                end else if (reqValid) begin
                    reqAccept_nxt = 1'b1;
                    // Refuse preemption off-class or without fabric
                    if (req.preempt && (!classOk || !fabricAttached)) begin
                        reqInvalid_nxt = 1'b1;
                    end else begin
                        txValid_nxt = 1'b1;
                        txFrame_nxt.sof = `DCP_SOF_C1;
                        txFrame_nxt.kind = `DCP_FK_DATA;
                        txFrame_nxt.eof = `DCP_EOF_N;
                        txFrame_nxt.sid = myId;
                        txFrame_nxt.did = req.dest;
                        txFrame_nxt.word4 = word4;
                        txFrame_nxt.reason = 8'h00;
                        peer_nxt = req.dest;
                        pendPreempt_nxt = req.preempt;
                        state_nxt = dcp_pkg::DCP_WAIT;
                    end
                end
            end
            dcp_pkg::DCP_WAIT: begin
                // No request or sequence is taken while waiting
                if (respMatch && isAck) begin
                    connected_nxt = 1'b1;
                    isInitiator_nxt = 1'b1;
                    reqDone_nxt = 1'b1;
                    state_nxt = dcp_pkg::DCP_CONN;
                end else if (respMatch && (rxFrame.kind == `DCP_FK_PBSY ||
                        rxFrame.kind == `DCP_FK_PRJT ||
                        (rxFrame.kind == `DCP_FK_FRJT &&
                        (!pendPreempt_r || isRjtPreempt)))) begin
                    reqFailed_nxt = 1'b1;
                    state_nxt = dcp_pkg::DCP_IDLE;
                end
            end
            dcp_pkg::DCP_CONN: begin
                if (disconnect) begin
                    connected_nxt = 1'b0;
                    isInitiator_nxt = 1'b0;
                    state_nxt = dcp_pkg::DCP_IDLE;
                end else if (seqValid) begin
                    seqAccept_nxt = 1'b1;
                    txValid_nxt = 1'b1;
                    txFrame_nxt.sof = `DCP_SOF_I1;
                    txFrame_nxt.kind = `DCP_FK_DATA;
                    txFrame_nxt.eof = `DCP_EOF_N;
                    txFrame_nxt.sid = myId;
                    txFrame_nxt.did = peer_r;
                    txFrame_nxt.reason = 8'h00;
                end
            end
            default: begin
                state_nxt = dcp_pkg::DCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= dcp_pkg::DCP_IDLE;
            txValid_r <= 1'b0;
            txFrame_r <= '0;
            connected_r <= 1'b0;
            isInitiator_r <= 1'b0;
            reqAccept_r <= 1'b0;
            reqDone_r <= 1'b0;
            reqFailed_r <= 1'b0;
            reqInvalid_r <= 1'b0;
            seqAccept_r <= 1'b0;
            pendPreempt_r <= 1'b0;
            peer_r <= 24'h00_0000;
        end else begin
            state_r <= state_nxt;
            txValid_r <= txValid_nxt;
            txFrame_r <= txFrame_nxt;
            connected_r <= connected_nxt;
            isInitiator_r <= isInitiator_nxt;
            reqAccept_r <= reqAccept_nxt;
            reqDone_r <= reqDone_nxt;
            reqFailed_r <= reqFailed_nxt;
            reqInvalid_r <= reqInvalid_nxt;
            seqAccept_r <= seqAccept_nxt;
            pendPreempt_r <= pendPreempt_nxt;
            peer_r <= peer_nxt;
        end
    end

    preempt_flag_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        reqValid && req.preempt && classOk && fabricAttached &&
        state_r == dcp_pkg::DCP_IDLE && !connReqIn |=>
        txValid_r && txFrame_r.sof == `DCP_SOF_C1 && txFrame_r.word4[31])
        else $error("preemption request not flagged");
    ack_connects_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_WAIT && respMatch && isAck |=>
        connected_r && isInitiator_r && reqDone_r)
        else $error("ack did not establish connection");
    rjt_ends_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_WAIT && respMatch &&
        rxFrame.kind == `DCP_FK_FRJT && isRjtPreempt |=>
        !connected_r && reqFailed_r && state_r == dcp_pkg::DCP_IDLE)
        else $error("reject did not end attempt");
    busy_reply_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_IDLE && connReqIn && portBusy |=>
        txValid_r && txFrame_r.kind == `DCP_FK_PBSY &&
        txFrame_r.eof == `DCP_EOF_DT && !connected_r)
        else $error("busy reply malformed");
    free_reply_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_IDLE && connReqIn && !portBusy |=>
        txFrame_r.sof == `DCP_SOF_N1 && connected_r && !isInitiator_r)
        else $error("recipient reply malformed");
    class_guard_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_IDLE && !connReqIn && reqValid &&
        req.preempt && !classOk |=> reqInvalid_r && !txValid_r)
        else $error("preemption sent for wrong class");
    fabric_only_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_IDLE && !connReqIn && reqValid &&
        req.preempt && !fabricAttached |=> reqInvalid_r)
        else $error("preemption without fabric");
    wait_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_WAIT |=> !txValid_r && !reqAccept_r)
        else $error("frame sent while awaiting response");
    seq_delim_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        seqAccept_r |-> txValid_r && txFrame_r.sof == `DCP_SOF_I1 &&
        $past(connected_r))
        else $error("sequence not framed with SOFi1");

    // $past recovers the request fields seen on the deciding edge, since
    // the request may already have been withdrawn when the frame stands
    prio_field_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_IDLE && !connReqIn && reqValid &&
        prioEnabled && (!req.preempt || (classOk && fabricAttached)) |=>
        txFrame_r.word4[30:24] == $past(req.prio) &&
        txFrame_r.word4[23:16] == $past(req.oxId[7:0]))
        else $error("priority field misplaced");
    oxid_only_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_IDLE && !connReqIn && reqValid &&
        !prioEnabled && (!req.preempt || (classOk && fabricAttached)) |=>
        txFrame_r.word4[30:16] == $past(req.oxId[14:0]) &&
        txFrame_r.word4[31] == $past(req.oxId[15] || req.preempt))
        else $error("originator id field misplaced");
    ack0_ignored_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_WAIT && pendPreempt_r && rxValid &&
        rxFrame.kind == `DCP_FK_ACK0 |=>
        !connected_r && state_r == dcp_pkg::DCP_WAIT)
        else $error("bare ack completed a preemption");
    rjt_other_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_WAIT && pendPreempt_r && respMatch &&
        rxFrame.kind == `DCP_FK_FRJT && !isRjtPreempt |=>
        state_r == dcp_pkg::DCP_WAIT)
        else $error("unrelated reject ended a preemption");
    plain_ack0_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_WAIT && !pendPreempt_r && respMatch &&
        rxFrame.kind == `DCP_FK_ACK0 && rxFrame.eof == `DCP_EOF_T |=>
        connected_r && isInitiator_r)
        else $error("plain ack did not connect");
    busy_fails_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_WAIT && !pendPreempt_r && respMatch &&
        rxFrame.kind == `DCP_FK_PBSY |=>
        reqFailed_r && state_r == dcp_pkg::DCP_IDLE)
        else $error("busy answer did not end request");
    disc_drops_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_CONN && disconnect |=>
        !connected_r && !isInitiator_r && !txValid_r)
        else $error("disconnect did not drop connection");
    conn_state_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        connected_r == (state_r == dcp_pkg::DCP_CONN))
        else $error("connection flag out of step with state");
    reply_ids_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        state_r == dcp_pkg::DCP_IDLE && connReqIn |=>
        txValid_r && txFrame_r.did == $past(rxFrame.sid) &&
        txFrame_r.sid == $past(myId))
        else $error("reply not addressed to requester");
    accept_idle_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        reqAccept_r |-> $past(state_r) == dcp_pkg::DCP_IDLE)
        else $error("request taken outside idle");
    fail_clean_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        reqFailed_r |-> !reqDone_r && !connected_r && !isInitiator_r)
        else $error("failed attempt left a connection");
    seq_dest_a: assert property (
        @(posedge ref_clk) disable iff (!reset_n)
        seqAccept_r |-> txFrame_r.did == peer_r && txFrame_r.sid == myId)
        else $error("sequence frame misaddressed");
endmodule : dcp_conn_ctrl

// ### verilog/dcp_regs.svh
`ifndef DCP_REGS_SVH
`define DCP_REGS_SVH
// Frame delimiter codes
`define DCP_SOF_C1 3'h1
`define DCP_SOF_N1 3'h2
`define DCP_SOF_I1 3'h3
`define DCP_SOF_OTHER 3'h0
`define DCP_EOF_N 2'h0
`define DCP_EOF_T 2'h1
`define DCP_EOF_DT 2'h2
// Frame kinds
`define DCP_FK_DATA 3'h0
`define DCP_FK_ACK1 3'h1
`define DCP_FK_ACKN 3'h2
`define DCP_FK_ACK0 3'h3
`define DCP_FK_FRJT 3'h4
`define DCP_FK_PBSY 3'h5
`define DCP_FK_PRJT 3'h6
// Word 4 field positions
`define DCP_W4_PREEMPT_BIT 31
`define DCP_W4_PRIO_HI 30
`define DCP_W4_PRIO_LO 24
`define DCP_W4_OXID_HI 23
`define DCP_W4_OXID_LO 16
// Fabric reject reason codes
`define DCP_RSN_PREEMPT_REJ 8'h01
`define DCP_RSN_PREEMPT_NEN 8'h02
// Service classes
`define DCP_CLASS_1 3'h1
`define DCP_CLASS_6 3'h6
`endif

// ### verilog/dcp_pkg.sv
package dcp_pkg;
    typedef struct packed {
        logic [2:0] sof;
        logic [2:0] kind;
        logic [1:0] eof;
        logic [23:0] sid;
        logic [23:0] did;
        logic [31:0] word4;
        logic [7:0] reason;
    } dcp_frame_t;

    typedef struct packed {
        logic [23:0] dest;
        logic [2:0] svcClass;
        logic [6:0] prio;
        logic [15:0] oxId;
        logic preempt;
    } dcp_req_t;

    typedef enum logic [1:0] {
        DCP_IDLE = 2'b00,
        DCP_WAIT = 2'b01,
        DCP_CONN = 2'b11
    } dcp_state_t;
endpackage : dcp_pkg

// ### verification/dcp_far_model.sv
`timescale 1ns/1ps
`include "dcp_regs.svh"
module dcp_far_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic txValid,
    input wire dcp_pkg::dcp_frame_t txFrame,
    input wire logic [2:0] respKind,
    input wire logic [1:0] respEof,
    input wire logic [7:0] respRsn,
    input wire logic [3:0] lat,
    input wire logic inject,
    input wire dcp_pkg::dcp_frame_t injFrame,
    output logic rxValid,
    output dcp_pkg::dcp_frame_t rxFrame
);
    dcp_pkg::dcp_frame_t pend;
    logic [3:0] cnt;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxValid <= 1'b0;
            rxFrame <= '0;
            cnt <= 4'h0;
        end else begin
            rxValid <= inject || cnt == 4'h1;
            // Idle lines never repeat the last frame
            rxFrame <= inject ? injFrame : cnt == 4'h1 ? pend : ~rxFrame;
            if (cnt != 4'h0) cnt <= cnt - 4'h1;
            if (txValid && txFrame.sof == `DCP_SOF_C1) begin
                cnt <= lat;
                // Reply on SOFn1 with ids swapped
                pend <= {`DCP_SOF_N1, respKind, respEof, txFrame.did,
                    txFrame.sid, 32'h0, respRsn};
            end
        end
    end
endmodule : dcp_far_model

// ### verification/tb_top.sv
`timescale 1ns/1ps
`include "dcp_regs.svh"
module tb_top;
    logic ref_clk = 0, reset_n = 0, fabricAttached = 1, prioEnabled = 1;
    logic portBusy = 0, disconnect = 0, reqValid = 0, seqValid = 0;
    logic inject = 0, rxValid, reqAccept_r, txValid_r, connected_r;
    logic isInitiator_r, reqDone_r, reqFailed_r, reqInvalid_r, seqAccept_r;
    logic [23:0] myId = 24'h0a0b0c, peer;
    logic [2:0] respKind = 3'h0;
    logic [1:0] respEof = 2'h0;
    logic [7:0] respRsn = 8'h00;
    logic [3:0] lat = 4'h1;
    dcp_pkg::dcp_req_t req = '0;
    dcp_pkg::dcp_frame_t injFrame = '0, rxFrame, txFrame_r, qTx[$];
    int n_mismatch = 0, check_count = 0, seed = 36, cyc = 0;
    int nD = 0, nF = 0, nI = 0, nS = 0, eD = 0, eF = 0, eI = 0, eS = 0;
    int nA = 0, eA = 0;

    dcp_conn_ctrl u_dcp_conn_ctrl (.ref_clk, .reset_n, .myId,
        .fabricAttached, .prioEnabled, .portBusy, .disconnect, .reqValid,
        .req, .seqValid, .rxValid, .rxFrame, .reqAccept_r, .txValid_r,
        .txFrame_r, .connected_r, .isInitiator_r, .reqDone_r, .reqFailed_r,
        .reqInvalid_r, .seqAccept_r);
    dcp_far_model u_dcp_far_model (.ref_clk, .reset_n, .txValid(txValid_r),
        .txFrame(txFrame_r), .respKind, .respEof, .respRsn, .lat, .inject,
        .injFrame, .rxValid, .rxFrame);

    always #5 ref_clk = ~ref_clk;

    function automatic dcp_pkg::dcp_frame_t fr(input logic [2:0] s, k,
        input logic [1:0] eo, input logic [23:0] sid, did,
        input logic [7:0] rs);
        return {s, k, eo, sid, did, 32'h0, rs};
    endfunction : fr

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task chkTx(input dcp_pkg::dcp_frame_t f);
        dcp_pkg::dcp_frame_t e;
        if (qTx.size() == 0) begin
            chk(1, 0);
            return;
        end
        e = qTx.pop_front();
        chk(f.sof, e.sof);
        chk({f.sid, f.did}, {e.sid, e.did});
        if (e.sof == `DCP_SOF_C1)
            chk(f.word4[31:16], e.word4[31:16]);
        if (e.sof == `DCP_SOF_N1)
            chk({f.kind, f.eof}, {e.kind, e.eof});
    endtask : chkTx

    // Counts move at the rising edge; tasks read them at the falling one
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 3000) begin
            n_mismatch++;
            finish_test();
        end
        nD += reqDone_r;
        nF += reqFailed_r;
        nI += reqInvalid_r;
        nS += seqAccept_r;
        nA += reqAccept_r;
        if (txValid_r) chkTx(txFrame_r);
    end

    task settle(input int d, f, i, input logic c, ini);
        eD += d;
        eF += f;
        eI += i;
        for (int k = 0; k < 20 && nD + nF + nI < eD + eF + eI; k++)
            @(negedge ref_clk);
        repeat (3) @(negedge ref_clk);
        chk(nD, eD);
        chk(nF, eF);
        chk(nI, eI);
        chk(nS, eS);
        chk({connected_r, isInitiator_r}, {c, ini});
        chk(nA, eA);
        chk(qTx.size(), 0);
        // Leave on a rising edge so the next stimulus lands there too
        @(posedge ref_clk);
    endtask : settle

    task doReq(input logic pre, input logic [2:0] cls, input logic ok);
        logic [6:0] pr;
        logic [15:0] ox;
        dcp_pkg::dcp_frame_t e;
        peer = 24'($random(seed));
        pr = 7'($random(seed));
        ox = 16'($random(seed));
        eA++;
        @(posedge ref_clk);
        e = fr(`DCP_SOF_C1, 3'h0, 2'h0, myId, peer, 8'h00);
        e.word4[31:16] = prioEnabled ? {pre, pr, ox[7:0]} : ox;
        e.word4[31] = e.word4[31] | pre;
        if (ok) qTx.push_back(e);
        lat <= 4'(($random(seed) & 3) + 1);
        req <= {peer, cls, pr, ox, pre};
        reqValid <= 1;
        @(posedge ref_clk);
        reqValid <= 0;
    endtask : doReq

    task rxIn(input dcp_pkg::dcp_frame_t f);
        @(posedge ref_clk);
        injFrame <= f;
        inject <= 1;
        @(posedge ref_clk);
        inject <= 0;
    endtask : rxIn

    task hold(input int n, input logic cut);
        eS += cut ? 0 : n;
        repeat (cut ? 0 : n) qTx.push_back(fr(`DCP_SOF_I1, 3'h0, 2'h0,
            myId, peer, 8'h00));
        @(posedge ref_clk);
        seqValid <= !cut;
        disconnect <= cut;
        repeat (n) @(posedge ref_clk);
        seqValid <= 0;
        disconnect <= 0;
    endtask : hold

    task resp(input logic [2:0] k, input logic [1:0] eo, input logic [7:0] r);
        respKind <= k;
        respEof <= eo;
        respRsn <= r;
    endtask : resp

    task incoming(input logic busy);
        peer = 24'($random(seed));
        qTx.push_back(fr(`DCP_SOF_N1, busy ? `DCP_FK_PBSY : `DCP_FK_ACK1,
            busy ? `DCP_EOF_DT : `DCP_EOF_N, myId, peer, 8'h00));
        portBusy <= busy;
        rxIn(fr(`DCP_SOF_C1, `DCP_FK_DATA, `DCP_EOF_N, peer, myId, 8'h00));
    endtask : incoming

    task finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1;
        resp(`DCP_FK_ACK1, `DCP_EOF_N, 8'h00);
        doReq(1, `DCP_CLASS_1, 1);
        settle(1, 0, 0, 1, 1);
        hold(2, 0);
        hold(1, 1);
        settle(0, 0, 0, 0, 0);
        prioEnabled <= 0;
        resp(`DCP_FK_FRJT, `DCP_EOF_DT, `DCP_RSN_PREEMPT_REJ);
        doReq(1, `DCP_CLASS_6, 1);
        settle(0, 1, 0, 0, 0);
        // A bare ACK_0 must not complete a preemption
        resp(`DCP_FK_ACK0, `DCP_EOF_N, 8'h00);
        doReq(1, `DCP_CLASS_1, 1);
        repeat (6) @(negedge ref_clk);
        // A reject for some other reason is not an answer either
        rxIn(fr(`DCP_SOF_N1, `DCP_FK_FRJT, `DCP_EOF_DT, peer, myId, 8'h03));
        repeat (3) @(negedge ref_clk);
        chk(nF, eF);
        rxIn(fr(`DCP_SOF_N1, `DCP_FK_FRJT, `DCP_EOF_DT, peer, myId,
            `DCP_RSN_PREEMPT_NEN));
        settle(0, 1, 0, 0, 0);
        doReq(1, 3'h2, 0);
        settle(0, 0, 1, 0, 0);
        fabricAttached <= 0;
        doReq(1, `DCP_CLASS_1, 0);
        settle(0, 0, 1, 0, 0);
        fabricAttached <= 1;
        prioEnabled <= 1;
        resp(`DCP_FK_PBSY, `DCP_EOF_DT, 8'h00);
        doReq(0, `DCP_CLASS_1, 1);
        settle(0, 1, 0, 0, 0);
        resp(`DCP_FK_ACK0, `DCP_EOF_T, 8'h00);
        doReq(0, `DCP_CLASS_6, 1);
        settle(1, 0, 0, 1, 1);
        hold(1, 1);
        incoming(0);
        settle(0, 0, 0, 1, 0);
        hold(2, 0);
        hold(1, 1);
        incoming(1);
        settle(0, 0, 0, 0, 0);
        finish_test();
    end
endmodule : tb_top
